// ### hw/pdm_defs.vh
// Purpose: Constants for the pin drive mode control block
// Assumes: 32-bit register bus, byte addresses on aligned words
// Notes:   Definitions only; included by its bare name
`ifndef PDM_DEFS_VH
`define PDM_DEFS_VH

// ----------------------------------------------------------------
// Register byte addresses, port form
// ----------------------------------------------------------------
`define PDM_A_DATA     8'h00
`define PDM_A_DM0      8'h04
`define PDM_A_DM1      8'h08
`define PDM_A_DM2      8'h0c
`define PDM_A_BYP      8'h10
`define PDM_A_LEVEL    8'h14
`define PDM_A_ITYPE    8'h18
`define PDM_A_ISTAT    8'h1c
`define PDM_A_IMASK    8'h20
`define PDM_A_REG_OUT  8'h24
`define PDM_A_USB_MODE 8'h28
`define PDM_A_USB_LVL  8'h2c

// ----------------------------------------------------------------
// Pin form: one word per general pin, one per usb pin
// ----------------------------------------------------------------
`define PDM_PIN_PAGE   3'h2
`define PDM_A_USB0     8'h60
`define PDM_A_USB1     8'h64

// Pin form field positions
`define PDM_PF_DATA    0
`define PDM_PF_DM_LO   1
`define PDM_PF_BYP     4
`define PDM_PF_IT_LO   5
`define PDM_PF_REG     7
// Usb pin form field positions
`define PDM_UF_DATA    0
`define PDM_UF_DRV     1
`define PDM_UF_PULL    2

// ----------------------------------------------------------------
// Drive mode codes
// ----------------------------------------------------------------
`define PDM_DM_HIZ_AN  3'h0
`define PDM_DM_HIZ_DIG 3'h1
`define PDM_DM_RES_UP  3'h2
`define PDM_DM_RES_DN  3'h3
`define PDM_DM_OD_LOW  3'h4
`define PDM_DM_OD_HIGH 3'h5
`define PDM_DM_STRONG  3'h6
`define PDM_DM_RES_UD  3'h7

// Edge interrupt types
`define PDM_IT_NONE    2'h0
`define PDM_IT_RISE    2'h1
`define PDM_IT_FALL    2'h2
`define PDM_IT_BOTH    2'h3

// Reset values
`define PDM_RST8       8'h00
`define PDM_RST16      16'h0000
`define PDM_RST2       2'h0
`define PDM_RST32      32'h0000_0000

`endif

// ### hw/pdm_pin_drive.v
// Purpose: Drive mode and input path control for one eight-pin port
//          plus a pair of usb capable pins
// Assumes: Pad inputs synchronous to clock_in; pad resistors are
//          enabled by the pull outputs, strong drive by oe_n low
// Notes:   All outputs are registered, so pad changes lag a write
//          by one clock
`timescale 1ns/10ps
`include "pdm_defs.vh"

// Function
// - Three-bit drive mode field per pin
// - Reset puts every general pin in analog high-Z
// - Digital high-Z: driver off, input on
// - Resistive up and down modes: one state resistive, other strong; up-down mode resistive in both
// - Open drain floats one state, drives other
// - Output from system when bypassed, else register
// - Input updates level register and digital system
// - Separate level and output value registers
// - Port form and pin form share storage
// - Edge interrupt per pin, one request per port
// - No level-sensitive pin interrupts
// - Usb pins: drive bit and pull-up bit
// - Usb pins: strong low; one per bits
// - Usb mode ignores bits; port writes skip
// - Regulated output disables resistive modes
module pdm_pin_drive (
  input  wire        clock_in,       // System clock, 250 MHz
  input  wire        rst_n_in,       // Synchronous reset, active low
  input  wire [7:0]  addr_in,        // Register byte address
  input  wire [31:0] wdata_in,       // Register write data
  input  wire        wr_in,          // Write strobe
  input  wire        rd_in,          // Read strobe
  output reg  [31:0] rdata_out,      // Read data, cycle after strobe
  input  wire [7:0]  pad_in,         // Pin levels seen at the pads
  output reg  [7:0]  pad_out,        // Value driven when oe_n low
  output reg  [7:0]  pad_oe_n_out,   // Strong drive enable, low = drive
  output reg  [7:0]  pull_up_out,    // Resistive pull-up enable
  output reg  [7:0]  pull_dn_out,    // Resistive pull-down enable
  output reg  [7:0]  in_buf_en_out,  // Digital input buffer enable
  input  wire [7:0]  sys_out_in,     // Output values from digital system
  output reg  [7:0]  sys_in_out,     // Pin levels to digital system
  input  wire [1:0]  usb_pad_in,     // Usb pin levels
  output reg  [1:0]  usb_pad_out,    // Usb pin drive value
  output reg  [1:0]  usb_oe_n_out,   // Usb strong drive, low = drive
  output reg  [1:0]  usb_pull_up_out,// Usb resistive pull-up enable
  output reg         irq_out         // Port interrupt request, level
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  reg  [7:0]  output_value_reg_r;   // Data written for the pins
  reg  [7:0]  dm0_r;                // Drive mode bit 0 per pin
  reg  [7:0]  dm1_r;                // Drive mode bit 1 per pin
  reg  [7:0]  dm2_r;                // Drive mode bit 2 per pin
  reg  [7:0]  byp_r;                // Output bypass select per pin
  reg  [15:0] itype_r;              // Edge type, two bits per pin
  reg  [7:0]  istat_r;              // Sticky edge status
  reg  [7:0]  imask_r;              // Interrupt mask
  reg  [7:0]  reg_out_r;            // Regulated output mode per pin
  reg         usb_mode_r;           // Usb pins handed to usb core
  reg  [1:0]  usb_data_r;           // Usb pin output values
  reg  [1:0]  usb_drv_r;            // Usb drive enable bits
  reg  [1:0]  usb_pull_r;           // Usb pull-up enable bits
  reg  [7:0]  pin_level_reg_r;      // Sampled pin levels
  reg  [1:0]  usb_level_r;          // Sampled usb pin levels

  // Next values
  reg  [7:0]  output_value_reg_nxt;
  reg  [7:0]  dm0_nxt;
  reg  [7:0]  dm1_nxt;
  reg  [7:0]  dm2_nxt;
  reg  [7:0]  byp_nxt;
  reg  [15:0] itype_nxt;
  reg  [7:0]  istat_nxt;
  reg  [7:0]  imask_nxt;
  reg  [7:0]  reg_out_nxt;
  reg         usb_mode_nxt;
  reg  [1:0]  usb_data_nxt;
  reg  [1:0]  usb_drv_nxt;
  reg  [1:0]  usb_pull_nxt;
  reg  [7:0]  pin_level_nxt;
  reg  [31:0] rdata_nxt;
  reg  [7:0]  pad_nxt;
  reg  [7:0]  oe_n_nxt;
  reg  [7:0]  pu_nxt;
  reg  [7:0]  pd_nxt;
  reg  [7:0]  ibuf_nxt;
  reg  [1:0]  usb_pad_nxt;
  reg  [1:0]  usb_oe_n_nxt;
  reg  [1:0]  usb_pu_nxt;
  reg  [7:0]  edge_hit;             // Qualified edges this cycle

  // Decode helpers
  wire        pin_page  = (addr_in[7:5] == `PDM_PIN_PAGE);
  wire [2:0]  pin_idx   = addr_in[4:2];
  wire        wr_usb0   = wr_in && (addr_in == `PDM_A_USB0);
  wire        wr_usb1   = wr_in && (addr_in == `PDM_A_USB1);

  integer i, j, k;                  // Loop indices, one per process

  // ----------------------------------------------------------------
  // Register writes, port form and pin form
  // ----------------------------------------------------------------
  // Both forms write the same flops, so software may mix them freely
  always @*
  begin
    output_value_reg_nxt = output_value_reg_r;
    dm0_nxt      = dm0_r;
    dm1_nxt      = dm1_r;
    dm2_nxt      = dm2_r;
    byp_nxt      = byp_r;
    itype_nxt    = itype_r;
    imask_nxt    = imask_r;
    reg_out_nxt  = reg_out_r;
    usb_mode_nxt = usb_mode_r;
    usb_data_nxt = usb_data_r;
    usb_drv_nxt  = usb_drv_r;
    usb_pull_nxt = usb_pull_r;
    if (wr_in)
    begin
      // Port form; usb drive bits have no port-wide home
      // port writes skip
      case (addr_in)
        `PDM_A_DATA:     output_value_reg_nxt = wdata_in[7:0];
        `PDM_A_DM0:      dm0_nxt      = wdata_in[7:0];
        `PDM_A_DM1:      dm1_nxt      = wdata_in[7:0];
        `PDM_A_DM2:      dm2_nxt      = wdata_in[7:0];
        `PDM_A_BYP:      byp_nxt      = wdata_in[7:0];
        `PDM_A_ITYPE:    itype_nxt    = wdata_in[15:0];
        `PDM_A_IMASK:    imask_nxt    = wdata_in[7:0];
        `PDM_A_REG_OUT:  reg_out_nxt  = wdata_in[7:0];
        `PDM_A_USB_MODE: usb_mode_nxt = wdata_in[0];
        default:         ;
      endcase
      if (pin_page)
      begin
        output_value_reg_nxt[pin_idx] = wdata_in[`PDM_PF_DATA];
        dm0_nxt[pin_idx]              = wdata_in[`PDM_PF_DM_LO];
        dm1_nxt[pin_idx]              = wdata_in[`PDM_PF_DM_LO + 1];
        dm2_nxt[pin_idx]              = wdata_in[`PDM_PF_DM_LO + 2];
        byp_nxt[pin_idx]              = wdata_in[`PDM_PF_BYP];
        itype_nxt[{pin_idx, 1'b0}]    = wdata_in[`PDM_PF_IT_LO];
        itype_nxt[{pin_idx, 1'b1}]    = wdata_in[`PDM_PF_IT_LO + 1];
        reg_out_nxt[pin_idx]          = wdata_in[`PDM_PF_REG];
      end
    end
    if (wr_usb0)
    begin
      usb_data_nxt[0] = wdata_in[`PDM_UF_DATA];
      usb_drv_nxt[0]  = wdata_in[`PDM_UF_DRV];
      usb_pull_nxt[0] = wdata_in[`PDM_UF_PULL];
    end
    if (wr_usb1)
    begin
      usb_data_nxt[1] = wdata_in[`PDM_UF_DATA];
      usb_drv_nxt[1]  = wdata_in[`PDM_UF_DRV];
      usb_pull_nxt[1] = wdata_in[`PDM_UF_PULL];
    end
  end

  // ----------------------------------------------------------------
  // Pin drive decode
  // ----------------------------------------------------------------
  // Decoded from the next mode and value so the pads follow a write
  // one clock later; regulated pins lose resistive states, which
  // then float instead of pulling
  always @*
  begin : drive_dec
    reg [2:0] mode;
    reg       val;
    reg       res_ok;
    mode   = 3'h0;
    val    = 1'b0;
    res_ok = 1'b0;
    for (i = 0; i < 8; i = i + 1)
    begin
      mode   = {dm2_nxt[i], dm1_nxt[i], dm0_nxt[i]};
      val    = byp_nxt[i] ? sys_out_in[i] : output_value_reg_nxt[i];
      res_ok = ~reg_out_nxt[i];
      pad_nxt[i]  = val;
      oe_n_nxt[i] = 1'b1;
      pu_nxt[i]   = 1'b0;
      pd_nxt[i]   = 1'b0;
      ibuf_nxt[i] = (mode != `PDM_DM_HIZ_AN);
      case (mode)
        `PDM_DM_HIZ_AN:  oe_n_nxt[i] = 1'b1;
        `PDM_DM_HIZ_DIG: oe_n_nxt[i] = 1'b1;
        `PDM_DM_RES_UP:
        begin
          oe_n_nxt[i] = val;
          pu_nxt[i]   = val & res_ok;
        end
        `PDM_DM_RES_DN:
        begin
          oe_n_nxt[i] = ~val;
          pd_nxt[i]   = ~val & res_ok;
        end
        `PDM_DM_OD_LOW:  oe_n_nxt[i] = val;
        `PDM_DM_OD_HIGH: oe_n_nxt[i] = ~val;
        `PDM_DM_STRONG:  oe_n_nxt[i] = 1'b0;
        `PDM_DM_RES_UD:
        begin
          pu_nxt[i] = val & res_ok;
          pd_nxt[i] = ~val & res_ok;
        end
        default:         oe_n_nxt[i] = 1'b1;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Usb pin drive decode
  // ----------------------------------------------------------------
  always @*
  begin
    for (j = 0; j < 2; j = j + 1)
    begin
      usb_pad_nxt[j] = usb_data_nxt[j];
      if (usb_mode_nxt)
      begin
        usb_oe_n_nxt[j] = 1'b1;
        usb_pu_nxt[j]   = 1'b0;
      end
      else if (!usb_data_nxt[j])
      begin
        usb_oe_n_nxt[j] = 1'b0;
        usb_pu_nxt[j]   = 1'b0;
      end
      else
      begin
        usb_oe_n_nxt[j] = ~usb_drv_nxt[j];
        usb_pu_nxt[j]   = usb_pull_nxt[j] & ~usb_drv_nxt[j];
      end
    end
  end

  // ----------------------------------------------------------------
  // Input path and edge detection
  // ----------------------------------------------------------------
  // A disabled buffer reads low, so an analog pin never makes edges
  always @*
  begin
    pin_level_nxt = pad_in & in_buf_en_out;
    for (k = 0; k < 8; k = k + 1)
    begin
      case (itype_r[2*k +: 2])
        `PDM_IT_RISE: edge_hit[k] = pin_level_nxt[k] & ~pin_level_reg_r[k];
        `PDM_IT_FALL: edge_hit[k] = ~pin_level_nxt[k] & pin_level_reg_r[k];
        `PDM_IT_BOTH: edge_hit[k] = pin_level_nxt[k] ^ pin_level_reg_r[k];
        default:      edge_hit[k] = 1'b0;
      endcase
    end
    // Sticky status; a new edge wins over a write-one clear
    istat_nxt = istat_r;
    if (wr_in && (addr_in == `PDM_A_ISTAT))
      istat_nxt = istat_r & ~wdata_in[7:0];
    istat_nxt = istat_nxt | edge_hit;
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // Level and output value sit at distinct addresses
  always @*
  begin
    rdata_nxt = `PDM_RST32;
    if (pin_page)
    begin
      rdata_nxt[`PDM_PF_DATA]           = output_value_reg_r[pin_idx];
      rdata_nxt[`PDM_PF_DM_LO]          = dm0_r[pin_idx];
      rdata_nxt[`PDM_PF_DM_LO + 1]      = dm1_r[pin_idx];
      rdata_nxt[`PDM_PF_DM_LO + 2]      = dm2_r[pin_idx];
      rdata_nxt[`PDM_PF_BYP]            = byp_r[pin_idx];
      rdata_nxt[`PDM_PF_IT_LO]          = itype_r[{pin_idx, 1'b0}];
      rdata_nxt[`PDM_PF_IT_LO + 1]      = itype_r[{pin_idx, 1'b1}];
      rdata_nxt[`PDM_PF_REG]            = reg_out_r[pin_idx];
    end
    else
    begin
      case (addr_in)
        `PDM_A_DATA:     rdata_nxt[7:0]  = output_value_reg_r;
        `PDM_A_DM0:      rdata_nxt[7:0]  = dm0_r;
        `PDM_A_DM1:      rdata_nxt[7:0]  = dm1_r;
        `PDM_A_DM2:      rdata_nxt[7:0]  = dm2_r;
        `PDM_A_BYP:      rdata_nxt[7:0]  = byp_r;
        `PDM_A_LEVEL:    rdata_nxt[7:0]  = pin_level_reg_r;
        `PDM_A_ITYPE:    rdata_nxt[15:0] = itype_r;
        `PDM_A_ISTAT:    rdata_nxt[7:0]  = istat_r;
        `PDM_A_IMASK:    rdata_nxt[7:0]  = imask_r;
        `PDM_A_REG_OUT:  rdata_nxt[7:0]  = reg_out_r;
        `PDM_A_USB_MODE: rdata_nxt[0]    = usb_mode_r;
        `PDM_A_USB_LVL:  rdata_nxt[1:0]  = usb_level_r;
        `PDM_A_USB0:
          rdata_nxt[2:0] = {usb_pull_r[0], usb_drv_r[0], usb_data_r[0]};
        `PDM_A_USB1:
          rdata_nxt[2:0] = {usb_pull_r[1], usb_drv_r[1], usb_data_r[1]};
        default:         rdata_nxt       = `PDM_RST32;
      endcase
    end
    // Data only stand in the cycle after a read
    if (!rd_in)
      rdata_nxt = `PDM_RST32;
  end

  // ----------------------------------------------------------------
  // Flip-flops
  // ----------------------------------------------------------------
  always @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      output_value_reg_r <= `PDM_RST8;
      dm0_r           <= `PDM_RST8;
      dm1_r           <= `PDM_RST8;
      dm2_r           <= `PDM_RST8;
      byp_r           <= `PDM_RST8;
      itype_r         <= `PDM_RST16;
      istat_r         <= `PDM_RST8;
      imask_r         <= `PDM_RST8;
      reg_out_r       <= `PDM_RST8;
      usb_mode_r      <= 1'b0;
      usb_data_r      <= `PDM_RST2;
      usb_drv_r       <= `PDM_RST2;
      usb_pull_r      <= `PDM_RST2;
      pin_level_reg_r <= `PDM_RST8;
      usb_level_r     <= `PDM_RST2;
      rdata_out       <= `PDM_RST32;
      pad_out         <= `PDM_RST8;
      pad_oe_n_out    <= ~`PDM_RST8;
      pull_up_out     <= `PDM_RST8;
      pull_dn_out     <= `PDM_RST8;
      in_buf_en_out   <= `PDM_RST8;
      sys_in_out      <= `PDM_RST8;
      usb_pad_out     <= `PDM_RST2;
      usb_oe_n_out    <= ~`PDM_RST2;
      usb_pull_up_out <= `PDM_RST2;
      irq_out         <= 1'b0;
    end
    else
    begin
      output_value_reg_r <= output_value_reg_nxt;
      dm0_r           <= dm0_nxt;
      dm1_r           <= dm1_nxt;
      dm2_r           <= dm2_nxt;
      byp_r           <= byp_nxt;
      itype_r         <= itype_nxt;
      istat_r         <= istat_nxt;
      imask_r         <= imask_nxt;
      reg_out_r       <= reg_out_nxt;
      usb_mode_r      <= usb_mode_nxt;
      usb_data_r      <= usb_data_nxt;
      usb_drv_r       <= usb_drv_nxt;
      usb_pull_r      <= usb_pull_nxt;
      pin_level_reg_r <= pin_level_nxt;
      usb_level_r     <= usb_pad_in;
      rdata_out       <= rdata_nxt;
      pad_out         <= pad_nxt;
      pad_oe_n_out    <= oe_n_nxt;
      pull_up_out     <= pu_nxt;
      pull_dn_out     <= pd_nxt;
      in_buf_en_out   <= ibuf_nxt;
      sys_in_out      <= pin_level_nxt;
      usb_pad_out     <= usb_pad_nxt;
      usb_oe_n_out    <= usb_oe_n_nxt;
      usb_pull_up_out <= usb_pu_nxt;
      irq_out         <= |(istat_nxt & imask_nxt);
    end
  end

endmodule // pdm_pin_drive

// ### bench/pdm_pin_world.sv
// Purpose: Board side of the pins: external drivers and resolved levels
// Assumes: Bench never drives a pin the device drives strongly
// Notes:   Undriven, unpulled pins toggle every clock so no stale level
//          can pass for a real one
`timescale 1ns/10ps
module pdm_pin_world #(
  parameter N = 8                        // Pins modelled
) (
  input  wire         clock_in,          // Bench clock
  input  wire [N-1:0] drv_val_in,        // Device drive value
  input  wire [N-1:0] drv_oe_n_in,       // Device strong drive, low = on
  input  wire [N-1:0] pu_in,             // Device pull-up on
  input  wire [N-1:0] pd_in,             // Device pull-down on
  input  wire [N-1:0] ext_en_in,         // External driver on
  input  wire [N-1:0] ext_val_in,        // External driver value
  output reg  [N-1:0] level_out          // Resolved pin level
);
  reg     tgl_r = 1'b0;                  // Float pattern
  integer i;                             // Pin index

  // Floating pattern flips each clock
  always @(posedge clock_in)
  begin
    tgl_r <= ~tgl_r;
  end

  // Strong drive wins, then external, then resistors, else float
  always @*
  begin
    for (i = 0; i < N; i = i + 1)
    begin
      if (!drv_oe_n_in[i])
        level_out[i] = drv_val_in[i];
      else if (ext_en_in[i])
        level_out[i] = ext_val_in[i];
      else if (pu_in[i] | pd_in[i])
        level_out[i] = pu_in[i];
      else
        level_out[i] = tgl_r;
    end
  end
endmodule // pdm_pin_world

// ### bench/pdm_pin_drive_properties.sv
// Purpose: Port-level checks of the pin drive block
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Sees only the top ports
`timescale 1ns/10ps
module pdm_pin_drive_props (
  input wire logic        clock_in,        // Clock
  input wire logic        rst_n_in,        // Reset, active low
  input wire logic [7:0]  addr_in,         // Address
  input wire logic [31:0] wdata_in,        // Write data
  input wire logic        wr_in,           // Write strobe
  input wire logic        rd_in,           // Read strobe
  input wire logic [31:0] rdata_out,       // Read data
  input wire logic [7:0]  pad_in,          // Pin levels
  input wire logic [7:0]  pad_oe_n_out,    // Strong drive, low = on
  input wire logic [7:0]  pull_up_out,     // Pull-up enables
  input wire logic [7:0]  pull_dn_out,     // Pull-down enables
  input wire logic [7:0]  in_buf_en_out,   // Input buffer enables
  input wire logic [7:0]  sys_in_out,      // Levels to system
  input wire logic [1:0]  usb_oe_n_out,    // Usb strong drive
  input wire logic [1:0]  usb_pull_up_out, // Usb pull-up
  input wire logic        irq_out          // Port interrupt
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_reset_state;
    $rose(rst_n_in) |-> pad_oe_n_out == 8'hff && usb_oe_n_out == 2'h3
      && in_buf_en_out == 8'h00 && !irq_out;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("pins not idle after reset");

  property p_analog_off;
    (~in_buf_en_out & (~pad_oe_n_out | pull_up_out | pull_dn_out)) == 8'h00;
  endproperty
  a_analog_off: assert property (p_analog_off) else $error("analog pin driven");

  property p_one_drive;
    (pull_up_out & pull_dn_out) == 8'h00
      && (~pad_oe_n_out & (pull_up_out | pull_dn_out)) == 8'h00;
  endproperty
  a_one_drive: assert property (p_one_drive) else $error("pin drive overlap");

  property p_buf_path;
    $past(rst_n_in) && $stable(in_buf_en_out)
      |-> sys_in_out == ($past(pad_in) & in_buf_en_out);
  endproperty
  a_buf_path: assert property (p_buf_path) else $error("system input wrong");

  property p_rd_idle;
    !$past(rd_in) |-> rdata_out == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");

  property p_mask_off;
    wr_in && addr_in == 8'h20 && wdata_in[7:0] == 8'h00 |-> ##2 !irq_out;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("irq despite mask");

  property p_irq_cause;
    $rose(irq_out) |-> $past(wr_in) || $past(wr_in, 2) || !$stable(sys_in_out)
      || $past(sys_in_out) != $past(sys_in_out, 2);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without edge");

  property p_usb_excl;
    (~usb_oe_n_out & usb_pull_up_out) == 2'h0;
  endproperty
  a_usb_excl: assert property (p_usb_excl) else $error("usb drive overlap");

  property p_usb_mode;
    wr_in && addr_in == 8'h28 && wdata_in[0]
      |-> ##2 usb_oe_n_out == 2'h3 && usb_pull_up_out == 2'h0;
  endproperty
  a_usb_mode: assert property (p_usb_mode) else $error("usb pins not released");
endmodule // pdm_pin_drive_props

bind pdm_pin_drive pdm_pin_drive_props u_props (.clock_in, .rst_n_in, .addr_in,
  .wdata_in, .wr_in, .rd_in, .rdata_out, .pad_in, .pad_oe_n_out, .pull_up_out,
  .pull_dn_out, .in_buf_en_out, .sys_in_out, .usb_oe_n_out, .usb_pull_up_out, .irq_out);

// ### bench/pin_drive_mode_control_test.sv
// Purpose: Self-checking bench for the pin drive block
// Assumes: Register map and pin forms as handed over
// Notes:   Each test resets first, so reset is also hit mid-run
`timescale 1ns/10ps
module pin_drive_mode_control_test;
  reg         clock_in = 1'b0;   // 250 MHz clock
  reg         rst_n_in = 1'b0;   // Reset, active low
  reg  [7:0]  addr_in = 8'h00;   // Bus address
  reg  [31:0] wdata_in = 32'h0;  // Bus write data
  reg         wr_in = 1'b0;      // Write strobe
  reg         rd_in = 1'b0;      // Read strobe
  reg  [7:0]  sys_out_in = 8'h00; // System output values
  reg  [7:0]  ext_en = 8'h00;    // External driver enables
  reg  [7:0]  ext_val = 8'h00;   // External driver values
  wire [31:0] rdata_out;         // Read data
  wire [7:0]  pad_in, pad_out, pad_oe_n_out, pull_up_out, pull_dn_out;
  wire [7:0]  in_buf_en_out, sys_in_out;
  wire [1:0]  usb_pad_in, usb_pad_out, usb_oe_n_out, usb_pull_up_out;
  wire        irq_out;           // Port interrupt
  integer     miscompares = 0;   // Failed compares
  integer     checks = 0;        // Compares made
  integer     cycles = 0;        // Watchdog count

  pdm_pin_drive DUT (.clock_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in,
    .rdata_out, .pad_in, .pad_out, .pad_oe_n_out, .pull_up_out, .pull_dn_out,
    .in_buf_en_out, .sys_out_in, .sys_in_out, .usb_pad_in, .usb_pad_out,
    .usb_oe_n_out, .usb_pull_up_out, .irq_out);
  pdm_pin_world #(.N(8)) pads (.clock_in, .drv_val_in(pad_out),
    .drv_oe_n_in(pad_oe_n_out), .pu_in(pull_up_out), .pd_in(pull_dn_out),
    .ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(pad_in));
  pdm_pin_world #(.N(2)) usb_pads (.clock_in, .drv_val_in(usb_pad_out),
    .drv_oe_n_in(usb_oe_n_out), .pu_in(usb_pull_up_out), .pd_in(2'h0),
    .ext_en_in(2'h0), .ext_val_in(2'h0), .level_out(usb_pad_in));

  // ----------------------------------------------------------------
  // Clock, watchdog and shared tasks
  // ----------------------------------------------------------------
  always #2 clock_in = ~clock_in;

  // A hang is cut short well past the few hundred cycles needed
  always @(posedge clock_in)
  begin
    cycles = cycles + 1;
    if (cycles == 8000)
    begin
      miscompares = miscompares + 1;
      tally_and_finish;
    end
  end

  task chk(input [31:0] got, input [31:0] exp, input string what);
  begin
    checks = checks + 1;
    if (got !== exp)
    begin
      miscompares = miscompares + 1;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  end
  endtask

  task wr(input [7:0] a, input [31:0] d);
  begin
    @(posedge clock_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clock_in);
    wr_in <= 1'b0;
  end
  endtask

  // Data stands only in the cycle after the strobe
  task rd(input [7:0] a, input [31:0] exp);
  begin
    @(posedge clock_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clock_in);
    rd_in <= 1'b0;
    #1;
    chk(rdata_out, exp, "read data");
  end
  endtask

  // Outputs are registered, so let two edges land
  task settle;
  begin
    repeat (2) @(posedge clock_in);
    #1;
  end
  endtask

  task ext(input [7:0] v);
  begin
    @(posedge clock_in);
    ext_val <= v;
    settle;
  end
  endtask

  task do_reset;
  begin
    @(posedge clock_in);
    rst_n_in <= 1'b0;
    ext_en <= 8'h00;
    sys_out_in <= 8'h00;
    repeat (16) @(posedge clock_in);
    rst_n_in <= 1'b1;
  end
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  task t_reset;
    reg [7:0] a;
  begin
    do_reset;
    #1;
    chk({pad_oe_n_out, in_buf_en_out, pull_up_out, pull_dn_out}, 32'hff00_0000, "pins");
    for (a = 8'h00; a < 8'h2c; a = a + 8'h04)
      rd(a, 32'h0);
    rd(8'h3c, 32'h0);
    $display("test reset done");
  end
  endtask

  task t_modes;
    reg [4:0] v;
    reg [2:0] c;
    reg       d, drv, pu, pd;
  begin
    do_reset;
    for (v = 5'h00; v < 5'h10; v = v + 5'h01)
    begin
      c = v[3:1];
      d = v[0];
      drv = c == 3'h6 || (c == 3'h2 && !d) || (c == 3'h3 && d) || (c == 3'h4 && !d)
        || (c == 3'h5 && d);
      pu = d && (c == 3'h2 || c == 3'h7);
      pd = !d && (c == 3'h3 || c == 3'h7);
      wr(8'h40, {28'h0, v[3:0]});
      settle;
      chk({28'h0, pad_oe_n_out[0], pull_up_out[0], pull_dn_out[0], in_buf_en_out[0]},
        {28'h0, !drv, pu, pd, c != 3'h0}, "mode");
      if (drv)
        chk({31'h0, pad_out[0]}, {31'h0, d}, "drive value");
      rd(8'h04, {31'h0, c[0]});
      rd(8'h0c, {31'h0, c[2]});
    end
    wr(8'h08, 32'h0000_00ff);
    rd(8'h44, 32'h0000_0004);
    rd(8'h40, 32'h0000_000f);
    $display("test modes done");
  end
  endtask

  task t_bypass;
  begin
    do_reset;
    sys_out_in <= 8'h02;
    wr(8'h44, 32'h0000_001c);
    settle;
    chk({30'h0, pad_oe_n_out[1], pad_out[1]}, 32'h1, "bypass out");
    rd(8'h14, 32'h0000_0002);
    rd(8'h00, 32'h0);
    chk({24'h0, sys_in_out}, 32'h2, "system in");
    wr(8'h10, 32'h0);
    settle;
    chk({30'h0, pad_oe_n_out[1], pad_out[1]}, 32'h0, "data out");
    $display("test bypass done");
  end
  endtask

  task t_irq;
    reg [2:0] t;
  begin
    do_reset;
    ext_en <= 8'h04;
    wr(8'h48, 32'h2);
    wr(8'h20, 32'h4);
    for (t = 3'h0; t < 3'h4; t = t + 3'h1)
    begin
      wr(8'h18, {26'h0, t[1:0], 4'h0});
      ext(8'h04);
      chk({31'h0, irq_out}, {31'h0, t[0]}, "rise irq");
      rd(8'h1c, {29'h0, t[0], 2'h0});
      wr(8'h1c, 32'h4);
      settle;
      chk({31'h0, irq_out}, 32'h0, "cleared");
      ext(8'h00);
      chk({31'h0, irq_out}, {31'h0, t[1]}, "fall irq");
      rd(8'h1c, {29'h0, t[1], 2'h0});
      wr(8'h1c, 32'h4);
      settle;
    end
    wr(8'h20, 32'h0);
    ext(8'h04);
    chk({31'h0, irq_out}, 32'h0, "masked");
    rd(8'h1c, 32'h4);
    wr(8'h20, 32'h4);
    settle;
    chk({31'h0, irq_out}, 32'h1, "unmasked");
    $display("test irq done");
  end
  endtask

  task t_usb;
    reg [3:0] v;
    reg       fl;
  begin
    do_reset;
    for (v = 4'h0; v < 4'h8; v = v + 4'h1)
    begin
      fl = v[0] && !v[1];
      wr(8'h60, {29'h0, v[2:0]});
      settle;
      // Usb pin 1 keeps data zero, so it drives a strong low throughout
      chk({29'h0, usb_oe_n_out, usb_pull_up_out[0]}, {29'h0, 1'b0, fl, fl & v[2]},
        "usb drive");
      if (!fl)
        chk({31'h0, usb_pad_out[0]}, {31'h0, v[0]}, "usb value");
    end
    wr(8'h60, 32'h1);
    wr(8'h04, 32'hffff_ffff);
    settle;
    chk({30'h0, usb_oe_n_out}, 32'h1, "port write");
    wr(8'h60, 32'h3);
    rd(8'h2c, 32'h1);
    wr(8'h28, 32'h1);
    settle;
    chk({28'h0, usb_oe_n_out, usb_pull_up_out}, 32'hc, "usb mode");
    $display("test usb done");
  end
  endtask

  task t_regulated;
  begin
    do_reset;
    wr(8'h4c, 32'h85);
    settle;
    chk({30'h0, pad_oe_n_out[3], pull_up_out[3]}, 32'h2, "reg pull-up");
    wr(8'h4c, 32'h84);
    settle;
    chk({30'h0, pad_oe_n_out[3], pull_up_out[3]}, 32'h0, "reg strong");
    wr(8'h4c, 32'h8e);
    settle;
    chk({30'h0, pad_oe_n_out[3], pull_dn_out[3]}, 32'h2, "reg pull-down");
    $display("test regulated done");
  end
  endtask

  task tally_and_finish;
  begin
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask

  initial
  begin
    t_reset;
    t_modes;
    t_bypass;
    t_irq;
    t_usb;
    t_regulated;
    tally_and_finish;
  end
endmodule // pin_drive_mode_control_test
